// ==== hw/dps_cfg.svh ====
`ifndef DPS_CFG_SVH
`define DPS_CFG_SVH

// ------------------------------------------------------------
// array geometry
// ------------------------------------------------------------
`define DPS_WORD_W 18
`define DPS_PAIR_AW 18
`define DPS_WORD_AW 19
`define DPS_NUM_WORDS 524288

// ------------------------------------------------------------
// field positions of the two byte lanes
// ------------------------------------------------------------
`define DPS_LO_MSB 8
`define DPS_LO_LSB 0
`define DPS_HI_MSB 17
`define DPS_HI_LSB 9

// ------------------------------------------------------------
// reset values
// ------------------------------------------------------------
`define DPS_WORD_RST 18'h00000
`define DPS_ADDR_RST 18'h00000
`define DPS_BWS_RST 2'h3

`endif

// ==== hw/dps_pkg.sv ====
`include "dps_cfg.svh"

package dps_pkg;

    // ------------------------------------------------------------
    // state of the positive input clock side
    // ------------------------------------------------------------
    typedef struct packed {
        logic rd_req;
        logic [`DPS_PAIR_AW-1:0] rd_addr;
        logic rd_vld;
        logic [`DPS_WORD_W-1:0] rd_lo;
        logic [`DPS_WORD_W-1:0] rd_hi;
        logic wr_req;
        logic [`DPS_WORD_W-1:0] wr_d0;
        logic [1:0] wr_lanes0;
        logic rd_tgl;
        logic wr_tgl;
    } dps_kpos_t;

    // ------------------------------------------------------------
    // state of the negative input clock side
    // ------------------------------------------------------------
    typedef struct packed {
        logic wr_go;
        logic [`DPS_PAIR_AW-1:0] wr_addr;
        logic [`DPS_WORD_W-1:0] wr_d1;
        logic [1:0] wr_lanes1;
    } dps_kneg_t;

    // ------------------------------------------------------------
    // output clock side
    // ------------------------------------------------------------
    typedef struct packed {
        logic oe;
        logic [`DPS_WORD_W-1:0] q_lo;
    } dps_cpos_t;

    typedef struct packed {
        logic [`DPS_WORD_W-1:0] q_hi;
    } dps_cneg_t;

    // ------------------------------------------------------------
    // core clock side: event crossing
    // ------------------------------------------------------------
    typedef struct packed {
        logic [2:0] rd_sync;
        logic [2:0] wr_sync;
        logic rd_pulse;
        logic wr_pulse;
    } dps_core_t;

endpackage

// ==== hw/dps_sram_if.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "dps_cfg.svh"

module dps_sram_if (
    input wire logic clk,
    input wire logic rst,
    input wire logic k_clk,
    input wire logic out_clk,
    input wire logic [`DPS_PAIR_AW-1:0] address,
    input wire logic read_port_select_n,
    input wire logic write_port_select_n,
    input wire logic byte_write_sel_low_n,
    input wire logic byte_write_sel_high_n,
    input wire logic [`DPS_WORD_W-1:0] data_in,
    output logic [`DPS_WORD_W-1:0] data_out,
    output logic data_out_oe,
    output logic rd_start_pulse,
    output logic wr_start_pulse
);

    // ------------------------------------------------------------
    // storage and state
    // ------------------------------------------------------------
    logic [`DPS_WORD_W-1:0] mem [0:`DPS_NUM_WORDS-1];
    dps_pkg::dps_kpos_t kp_r;
    dps_pkg::dps_kpos_t kp_nxt;
    dps_pkg::dps_kneg_t kn_r;
    dps_pkg::dps_kneg_t kn_nxt;
    dps_pkg::dps_cpos_t cp_r;
    dps_pkg::dps_cpos_t cp_nxt;
    dps_pkg::dps_cneg_t cn_r;
    dps_pkg::dps_cneg_t cn_nxt;
    dps_pkg::dps_core_t co_r;
    dps_pkg::dps_core_t co_nxt;
    logic [1:0] bws_now;

    // merge a beat into a stored word, lane by lane; low select is active
    function automatic logic [`DPS_WORD_W-1:0] dps_merge(
        input logic [`DPS_WORD_W-1:0] old_w,
        input logic [`DPS_WORD_W-1:0] new_w,
        input logic [1:0] bws_n
    );
        logic [`DPS_WORD_W-1:0] res;
        res = old_w;
        if (!bws_n[0])
        begin
            res[`DPS_LO_MSB:`DPS_LO_LSB] = new_w[`DPS_LO_MSB:`DPS_LO_LSB];
        end
        if (!bws_n[1])
        begin
            res[`DPS_HI_MSB:`DPS_HI_LSB] = new_w[`DPS_HI_MSB:`DPS_HI_LSB];
        end
        return res;
    endfunction

    assign bws_now = {byte_write_sel_high_n, byte_write_sel_low_n};

    // ------------------------------------------------------------
    // positive input clock: selects, read address, first write beat
    // ------------------------------------------------------------

    // pins here are synchronous to k_clk by the link's own timing
    always_comb
    begin
        kp_nxt = kp_r;
        kp_nxt.rd_req = !read_port_select_n;
        if (!read_port_select_n)
        begin
            kp_nxt.rd_addr = address;
            kp_nxt.rd_tgl = !kp_r.rd_tgl;
        end
        // address held when deselected, so a stray bus value never reaches the array
        kp_nxt.rd_vld = kp_r.rd_req;
        if (kp_r.rd_req)
        begin
            kp_nxt.rd_lo = mem[{kp_r.rd_addr, 1'b0}];
            kp_nxt.rd_hi = mem[{kp_r.rd_addr, 1'b1}];
        end
        kp_nxt.wr_req = !write_port_select_n;
        if (!write_port_select_n)
        begin
            kp_nxt.wr_d0 = data_in;
            kp_nxt.wr_lanes0 = bws_now;
            kp_nxt.wr_tgl = !kp_r.wr_tgl;
        end
        else
        begin
            kp_nxt.wr_lanes0 = `DPS_BWS_RST;
        end
    end

    always_ff @(posedge k_clk or posedge rst)
    begin
        if (rst)
        begin
            kp_r <= '0;
            kp_r.wr_lanes0 <= `DPS_BWS_RST;
        end
        else
        begin
            kp_r <= kp_nxt;
        end
    end

    // ------------------------------------------------------------
    // negative input clock: write address and second write beat
    // ------------------------------------------------------------

    // k-bar rise is taken as the falling edge of k_clk
    always_comb
    begin
        kn_nxt = kn_r;
        kn_nxt.wr_go = kp_r.wr_req;
        if (kp_r.wr_req)
        begin
            kn_nxt.wr_addr = address;
            kn_nxt.wr_d1 = data_in;
            kn_nxt.wr_lanes1 = bws_now;
        end
        else
        begin
            kn_nxt.wr_lanes1 = `DPS_BWS_RST;
        end
    end

    always_ff @(negedge k_clk or posedge rst)
    begin
        if (rst)
        begin
            kn_r <= '0;
            kn_r.wr_lanes1 <= `DPS_BWS_RST;
        end
        else
        begin
            kn_r <= kn_nxt;
        end
    end

    // ------------------------------------------------------------
    // array update
    // ------------------------------------------------------------

    // both beats commit at the next k rise; a read of the same pair
    // in that edge still sees the old contents
    always_ff @(posedge k_clk)
    begin
        if (kn_r.wr_go)
        begin
            mem[{kn_r.wr_addr, 1'b0}] <=
                dps_merge(mem[{kn_r.wr_addr, 1'b0}], kp_r.wr_d0, kp_r.wr_lanes0);
            mem[{kn_r.wr_addr, 1'b1}] <=
                dps_merge(mem[{kn_r.wr_addr, 1'b1}], kn_r.wr_d1, kn_r.wr_lanes1);
        end
    end

    // ------------------------------------------------------------
    // output clock: ddr launch of the read burst
    // ------------------------------------------------------------

    // out_clk carries c, or k itself in single clock mode; it lags k
    // by less than half a period so the word is stable when taken
    always_comb
    begin
        cp_nxt = cp_r;
        cp_nxt.oe = kp_r.rd_vld;
        cp_nxt.q_lo = kp_r.rd_lo;
        cn_nxt = cn_r;
        cn_nxt.q_hi = kp_r.rd_hi;
    end

    always_ff @(posedge out_clk or posedge rst)
    begin
        if (rst)
        begin
            cp_r <= '0;
        end
        else
        begin
            cp_r <= cp_nxt;
        end
    end

    always_ff @(negedge out_clk or posedge rst)
    begin
        if (rst)
        begin
            cn_r <= '0;
        end
        else
        begin
            cn_r <= cn_nxt;
        end
    end

    // ddr output cell: high phase shows the low word, low phase the high word
    assign data_out = out_clk ? cp_r.q_lo : cn_r.q_hi;
    assign data_out_oe = cp_r.oe;

    // ------------------------------------------------------------
    // core clock: access events crossed by toggle
    // ------------------------------------------------------------

    // bit 0 is the catching flop, read only by bit 1
    always_comb
    begin
        co_nxt = co_r;
        co_nxt.rd_sync = {co_r.rd_sync[1:0], kp_r.rd_tgl};
        co_nxt.wr_sync = {co_r.wr_sync[1:0], kp_r.wr_tgl};
        co_nxt.rd_pulse = co_r.rd_sync[2] ^ co_r.rd_sync[1];
        co_nxt.wr_pulse = co_r.wr_sync[2] ^ co_r.wr_sync[1];
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            co_r <= '0;
        end
        else
        begin
            co_r <= co_nxt;
        end
    end

    assign rd_start_pulse = co_r.rd_pulse;
    assign wr_start_pulse = co_r.wr_pulse;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    logic [`DPS_WORD_W-1:0] w1_now;
    assign w1_now = mem[{kn_r.wr_addr, 1'b1}];
    logic [`DPS_WORD_W-1:0] w0_now;
    assign w0_now = mem[{kn_r.wr_addr, 1'b0}];

    sequence s_rd_taken;
        !read_port_select_n;
    endsequence

    sequence s_rd_burst;
        kp_r.rd_req ##1 kp_r.rd_vld;
    endsequence

    sequence s_wr_taken;
        !write_port_select_n ##1 kp_r.wr_req;
    endsequence

    a_rd_addr_latch: assert property (@(posedge k_clk) disable iff (rst)
        s_rd_taken |=> kp_r.rd_req && kp_r.rd_addr == $past(address))
        else $error("read address not latched at k rise");

    a_rd_addr_ignore: assert property (@(posedge k_clk) disable iff (rst)
        read_port_select_n |=> !kp_r.rd_req && $stable(kp_r.rd_addr))
        else $error("read address taken while read port deselected");

    a_rd_two_words: assert property (@(posedge k_clk) disable iff (rst)
        s_rd_taken ##1 s_rd_burst |-> kp_r.rd_lo == $past(mem[{kp_r.rd_addr, 1'b0}])
            && kp_r.rd_hi == $past(mem[{kp_r.rd_addr, 1'b1}]))
        else $error("read burst words do not match the addressed pair");

    a_rd_release: assert property (@(posedge out_clk) disable iff (rst)
        !kp_r.rd_vld ##1 !kp_r.rd_vld |-> !data_out_oe)
        else $error("read outputs still driven after deselect");

    a_wr_start: assert property (@(posedge k_clk) disable iff (rst)
        !write_port_select_n |=> kp_r.wr_req && kp_r.wr_d0 == $past(data_in))
        else $error("write not started on select");

    a_wr_deselect: assert property (@(posedge k_clk) disable iff (rst)
        write_port_select_n |=> !kp_r.wr_req && !kn_r.wr_go)
        else $error("deselected write port still writing");

    a_wr_addr_neg: assert property (@(negedge k_clk) disable iff (rst)
        kp_r.wr_req |=> kn_r.wr_go && kn_r.wr_addr == $past(address))
        else $error("write address not taken at negative clock rise");

    a_wr_beat_hi: assert property (@(posedge k_clk) disable iff (rst)
        kn_r.wr_go && !kn_r.wr_lanes1[0] |=>
            mem[{$past(kn_r.wr_addr), 1'b1}][8:0] == $past(kn_r.wr_d1[8:0]))
        else $error("second beat low byte not written to high word");

    a_wr_byte_keep: assert property (@(posedge k_clk) disable iff (rst)
        kn_r.wr_go && kn_r.wr_lanes1[1] |=>
            mem[{$past(kn_r.wr_addr), 1'b1}][17:9] == $past(w1_now[17:9]))
        else $error("deselected byte was altered");

    // ------------------------------------------------------------
    // checks: write port, first beat and idle behaviour
    // ------------------------------------------------------------

    // the first beat waits in the positive-edge flops until the commit edge,
    // so its lanes are judged against the word one cycle after that edge
    a_wr_beat_lo: assert property (@(posedge k_clk) disable iff (rst)
        kn_r.wr_go && !kp_r.wr_lanes0[0] |=>
            mem[{$past(kn_r.wr_addr), 1'b0}][8:0] == $past(kp_r.wr_d0[8:0]))
        else $error("first beat low byte not written to low word");

    a_wr_hi_lane: assert property (@(posedge k_clk) disable iff (rst)
        kn_r.wr_go && !kp_r.wr_lanes0[1] |=>
            mem[{$past(kn_r.wr_addr), 1'b0}][17:9] == $past(kp_r.wr_d0[17:9]))
        else $error("first beat high byte not written to low word");

    a_wr_lo_keep: assert property (@(posedge k_clk) disable iff (rst)
        kn_r.wr_go && kp_r.wr_lanes0[1] |=>
            mem[{$past(kn_r.wr_addr), 1'b0}][17:9] == $past(w0_now[17:9]))
        else $error("deselected byte of the low word was altered");

    // a deselected cycle must leave no byte enabled behind it
    a_wr_lanes_idle: assert property (@(posedge k_clk) disable iff (rst)
        write_port_select_n |=> kp_r.wr_lanes0 == `DPS_BWS_RST)
        else $error("byte selects kept after write deselect");

    a_wr_addr_hold: assert property (@(negedge k_clk) disable iff (rst)
        !kp_r.wr_req |=> !kn_r.wr_go && $stable(kn_r.wr_addr))
        else $error("write address taken while write port deselected");

    a_wr_commit: assert property (@(posedge k_clk) disable iff (rst)
        s_wr_taken |-> kn_r.wr_go)
        else $error("write not armed for the next positive clock rise");

    // ------------------------------------------------------------
    // checks: read port, burst slot and launch
    // ------------------------------------------------------------

    // a lone read owns exactly one burst slot, then the drivers let go
    a_rd_vld_once: assert property (@(posedge k_clk) disable iff (rst)
        s_rd_taken ##1 read_port_select_n |=> kp_r.rd_vld ##1 !kp_r.rd_vld)
        else $error("read burst slot not exactly one cycle long");

    // burst words stay put without a read, so an idle port never shows new data
    a_rd_data_hold: assert property (@(posedge k_clk) disable iff (rst)
        !kp_r.rd_req |=> $stable(kp_r.rd_lo) && $stable(kp_r.rd_hi))
        else $error("burst words changed without a read");

    a_rd_lo_launch: assert property (@(posedge out_clk) disable iff (rst)
        kp_r.rd_vld |=> data_out_oe && cp_r.q_lo == $past(kp_r.rd_lo))
        else $error("low word not launched at output clock rise");

    a_rd_hi_launch: assert property (@(negedge out_clk) disable iff (rst)
        kp_r.rd_vld |=> cn_r.q_hi == $past(kp_r.rd_hi))
        else $error("high word not launched at output clock fall");

endmodule

`default_nettype wire

// ==== bench/dps_ctrl_model.sv ====
`timescale 1ns/10ps
`default_nettype none

// ------------------------------------------------------------
// memory controller model: input clock pair, address, selects
// ------------------------------------------------------------
module dps_ctrl_model (
    output logic k_clk,
    output logic out_clk,
    output logic [17:0] address,
    output logic read_port_select_n,
    output logic write_port_select_n,
    output logic byte_write_sel_low_n,
    output logic byte_write_sel_high_n,
    output logic [17:0] data_in
);
    // output clock lags the input clock, board style single domain
    assign #2 out_clk = k_clk;

    // free running input clock, phase unrelated to the core clock
    initial
    begin
        k_clk = 1'b0;
        address = 18'h00000;
        read_port_select_n = 1'b1;
        write_port_select_n = 1'b1;
        byte_write_sel_low_n = 1'b1;
        byte_write_sel_high_n = 1'b1;
        data_in = 18'h00000;
        #3;
        forever #6 k_clk = ~k_clk;
    end

    // write burst: beat0 and select for the rise, address and beat1 for the fall
    task automatic wr(input logic [17:0] a, input logic [17:0] d0, input logic [17:0] d1,
                      input logic [1:0] m0, input logic [1:0] m1, input logic sel_n);
        @(negedge k_clk);
        write_port_select_n <= sel_n;
        data_in <= d0;
        {byte_write_sel_high_n, byte_write_sel_low_n} <= m0;
        @(posedge k_clk);
        address <= a;
        data_in <= d1;
        {byte_write_sel_high_n, byte_write_sel_low_n} <= m1;
        @(negedge k_clk);
        // released data and address lines show the inverse so stale values never pass
        write_port_select_n <= 1'b1;
        data_in <= ~d1;
        address <= ~a;
        {byte_write_sel_high_n, byte_write_sel_low_n} <= 2'h3;
    endtask

    // read request held across one input clock rise
    task automatic rd_req(input logic [17:0] a);
        @(negedge k_clk);
        read_port_select_n <= 1'b0;
        address <= a;
        @(posedge k_clk);
    endtask

    task automatic rd_idle();
        @(negedge k_clk);
        read_port_select_n <= 1'b1;
        address <= ~address;
    endtask
endmodule

`default_nettype wire

// ==== bench/test_dual_port_ddr_burst_sram_if.sv ====
`timescale 1ns/10ps
`default_nettype none

module test_dual_port_ddr_burst_sram_if;
    logic clk;
    logic rst;
    wire logic k_clk;
    wire logic out_clk;
    wire logic [17:0] address;
    wire logic read_port_select_n;
    wire logic write_port_select_n;
    wire logic bw_lo_n;
    wire logic bw_hi_n;
    wire logic [17:0] data_in;
    logic [17:0] data_out;
    logic data_out_oe;
    logic rd_start_pulse;
    logic wr_start_pulse;
    int failures;
    int tests_run;
    int cyc;
    int wr_seen;
    int rd_seen;
    // sized like the device, so untouched words stay unknown on both sides
    logic [17:0] mir [0:524287];

    dps_ctrl_model i_dps_ctrl_model (.k_clk(k_clk), .out_clk(out_clk), .address(address),
        .read_port_select_n(read_port_select_n), .write_port_select_n(write_port_select_n),
        .byte_write_sel_low_n(bw_lo_n), .byte_write_sel_high_n(bw_hi_n), .data_in(data_in));

    dps_sram_if i_dps_sram_if (.clk(clk), .rst(rst), .k_clk(k_clk), .out_clk(out_clk),
        .address(address), .read_port_select_n(read_port_select_n),
        .write_port_select_n(write_port_select_n),
        .byte_write_sel_low_n(bw_lo_n), .byte_write_sel_high_n(bw_hi_n),
        .data_in(data_in), .data_out(data_out), .data_out_oe(data_out_oe),
        .rd_start_pulse(rd_start_pulse), .wr_start_pulse(wr_start_pulse));

    // ------------------------------------------------------------
    // clock, hang guard, event counting
    // ------------------------------------------------------------
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (wr_start_pulse === 1'b1)
            wr_seen <= wr_seen + 1;
        if (rd_start_pulse === 1'b1)
            rd_seen <= rd_seen + 1;
        if (cyc == 5000)
        begin
            failures = failures + 1;
            wrap_up();
        end
    end

    task automatic check(input string name, input logic [17:0] seen, input logic [17:0] exp);
        tests_run = tests_run + 1;
        if (seen !== exp)
        begin
            failures = failures + 1;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // lane merge kept apart from the design: selected lanes take new bits
    function automatic logic [17:0] merge(input logic [17:0] o, input logic [17:0] n,
                                          input logic [1:0] m);
        merge = o;
        if (!m[0])
            merge[8:0] = n[8:0];
        if (!m[1])
            merge[17:9] = n[17:9];
    endfunction

    task automatic wr(input logic [17:0] a, input logic [17:0] d0, input logic [17:0] d1,
                      input logic [1:0] m0, input logic [1:0] m1, input logic sel_n);
        i_dps_ctrl_model.wr(a, d0, d1, m0, m1, sel_n);
        if (!sel_n)
        begin
            mir[{a, 1'b0}] = merge(mir[{a, 1'b0}], d0, m0);
            mir[{a, 1'b1}] = merge(mir[{a, 1'b1}], d1, m1);
        end
    endtask

    // one burst seen on the output clock: low word while high, high word while low
    task automatic burst(input logic [17:0] a);
        @(posedge out_clk) #1;
        check("oe", {17'h00000, data_out_oe}, 18'h00001);
        check("low word", data_out, mir[{a, 1'b0}]);
        @(negedge out_clk) #1;
        check("high word", data_out, mir[{a, 1'b1}]);
    endtask

    // one or two back to back reads, then release and watch the drivers let go
    task automatic reads(input int n, input logic [17:0] a0, input logic [17:0] a1);
        fork
            begin
                i_dps_ctrl_model.rd_req(a0);
                if (n > 1)
                    i_dps_ctrl_model.rd_req(a1);
                i_dps_ctrl_model.rd_idle();
            end
            begin
                @(negedge read_port_select_n);
                @(posedge k_clk);
                @(posedge k_clk);
                burst(a0);
                if (n > 1)
                    burst(a1);
                @(posedge out_clk) #1;
                check("oe off", {17'h00000, data_out_oe}, 18'h00000);
            end
        join
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_full_pair();
        wr(18'h00005, 18'h2A5A5, 18'h15A5A, 2'h0, 2'h0, 1'b0);
        wr(18'h3FFFF, 18'h3FFFF, 18'h00001, 2'h0, 2'h0, 1'b0);
        repeat (2) @(posedge k_clk);
        reads(1, 18'h00005, 18'h00000);
        reads(2, 18'h3FFFF, 18'h00005);
    endtask

    task automatic t_byte_lanes();
        wr(18'h00005, 18'h00000, 18'h3FFFF, 2'h2, 2'h1, 1'b0);
        wr(18'h3FFFF, 18'h3FFFF, 18'h3FFFF, 2'h3, 2'h3, 1'b0);
        repeat (2) @(posedge k_clk);
        reads(2, 18'h00005, 18'h3FFFF);
    endtask

    task automatic t_deselect();
        wr(18'h00005, 18'h11111, 18'h22222, 2'h0, 2'h0, 1'b1);
        repeat (2) @(posedge k_clk);
        reads(1, 18'h00005, 18'h00000);
        repeat (4) @(posedge out_clk);
        #1;
        check("idle oe", {17'h00000, data_out_oe}, 18'h00000);
    endtask

    initial
    begin
        rst = 1'b1;
        failures = 0;
        tests_run = 0;
        cyc = 0;
        wr_seen = 0;
        rd_seen = 0;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        repeat (3) @(posedge k_clk);
        #1;
        check("reset oe", {17'h00000, data_out_oe}, 18'h00000);
        t_full_pair();
        t_byte_lanes();
        t_deselect();
        repeat (10) @(posedge clk);
        check("write starts", 18'(wr_seen), 18'h00004);
        check("read starts", 18'(rd_seen), 18'h00006);
        wrap_up();
    end
endmodule

`default_nettype wire
